//--- rtl/eeprom_status_block_protect.sv
`include "eeprom_prot_cfg.svh"
module eeprom_status_block_protect
  import eeprom_prot_pkg::*;
#(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic write_protect_pin_n,
  output logic serial_out,
  output logic serial_out_en,
  output logic array_write_valid,
  output logic [14:0] array_write_addr,
  output logic [7:0] array_write_data,
  output logic id_write_valid,
  output logic id_lock_valid,
  output logic [7:0] status_word
);
  // ===========================================================
  // Core side state (system clock)
  logic [2:0] nv_bits_ff;
  logic write_latch_ff;
  logic busy_ff;
  logic [31:0] busy_cnt_ff;
  logic [1:0] wp_sync_ff;
  logic [7:0] status_ff;
  logic array_write_valid_ff;
  logic [14:0] array_write_addr_ff;
  logic [7:0] array_write_data_ff;
  logic id_write_valid_ff;
  logic id_lock_valid_ff;

  // ===========================================================
  // Link side state (serial clock)
  frame_state_t state_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] opcode_ff;
  logic [15:0] addr_ff;
  logic addr_byte_ff;
  logic [7:0] data_ff;
  logic data_full_ff;
  logic [7:0] out_shift_ff;
  logic out_active_ff;
  logic so_ff;
  logic so_en_ff;
  logic ev_tgl_ff;
  logic [23:0] ev_word_ff;

  // ===========================================================
  // Snapshot of the status word into the link domain
  logic [7:0] status_link1_ff;
  logic [7:0] status_link2_ff;

  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      status_link1_ff <= 8'h00;
      status_link2_ff <= 8'h00;
    end else begin
      status_link1_ff <= status_ff;
      status_link2_ff <= status_link1_ff;
    end
  end

  // ===========================================================
  // Bit shifting and frame decode on the link clock
  wire [7:0] shift_next = {shift_ff[6:0], serial_in};
  wire byte_done = (bit_cnt_ff == 3'h7);
  wire is_read_status = (shift_next == `OP_STATUS_READ);
  wire frame_array = (opcode_ff == `OP_ARRAY_WRITE);
  wire frame_id = (opcode_ff == `OP_ID_WRITE);

  always_ff @(posedge serial_clock or posedge chip_select_n or posedge reset) begin
    if (reset || chip_select_n) begin
      state_ff <= ST_CMD;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      opcode_ff <= 8'h00;
      addr_ff <= 16'h0000;
      addr_byte_ff <= 1'b0;
      out_active_ff <= 1'b0;
    end else begin
      shift_ff <= shift_next;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done) begin
        case (state_ff)
          ST_CMD: begin
            opcode_ff <= shift_next;
            out_active_ff <= is_read_status;
            if (shift_next == `OP_ARRAY_WRITE || shift_next == `OP_ID_WRITE) begin
              state_ff <= ST_ADDR;
            end else if (shift_next == `OP_STATUS_WRITE) begin
              state_ff <= ST_DATA;
            end else begin
              state_ff <= ST_DONE;
            end
          end
          ST_ADDR: begin
            addr_ff <= {addr_ff[7:0], shift_next};
            addr_byte_ff <= 1'b1;
            if (addr_byte_ff) begin
              state_ff <= ST_DATA;
            end
          end
          ST_DATA: begin
            state_ff <= ST_DONE;
          end
          ST_DONE: begin
            state_ff <= ST_DONE;
          end
          default: begin
            state_ff <= ST_DONE;
          end
        endcase
      end
    end
  end

  // Last data byte held until chip select rises; any further clock rise cancels the write
  wire data_last = byte_done && state_ff == ST_DATA;

  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      data_ff <= 8'h00;
      data_full_ff <= 1'b0;
    end else if (!chip_select_n) begin
      data_full_ff <= data_last;
      if (data_last) begin
        data_ff <= shift_next;
      end
    end
  end

  // Short commands act at the eighth rise; write-type commands at chip select release
  wire short_done = byte_done && state_ff == ST_CMD &&
                    (shift_next == `OP_WRITE_ENABLE || shift_next == `OP_WRITE_DISABLE);

  always_ff @(posedge serial_clock or posedge reset) begin
    if (reset) begin
      ev_tgl_ff <= 1'b0;
      ev_word_ff <= 24'h000000;
    end else if (!chip_select_n && short_done) begin
      ev_tgl_ff <= ~ev_tgl_ff;
      ev_word_ff <= {shift_next, 16'h0000};
    end
  end

  // Opcode, address and data frozen at chip select rise, held until the next write frame
  logic end_tgl_ff;
  logic [31:0] end_word_ff;
  always_ff @(posedge chip_select_n or posedge reset) begin
    if (reset) begin
      end_tgl_ff <= 1'b0;
      end_word_ff <= 32'h00000000;
    end else if (data_full_ff && (frame_array || frame_id || opcode_ff == `OP_STATUS_WRITE)) begin
      end_tgl_ff <= ~end_tgl_ff;
      end_word_ff <= {opcode_ff, addr_ff, data_ff};
    end
  end

  // Output shift on falling edge
  // Chip select release frees the output at once, the serial clock idles low
  always_ff @(negedge serial_clock or posedge chip_select_n or posedge reset) begin
    if (reset || chip_select_n) begin
      so_ff <= 1'b0;
      so_en_ff <= 1'b0;
      out_shift_ff <= 8'h00;
    end else if (out_active_ff) begin
      so_en_ff <= 1'b1;
      if (bit_cnt_ff == 3'h0) begin
        so_ff <= status_link2_ff[7];
        out_shift_ff <= {status_link2_ff[6:0], 1'b0};
      end else begin
        so_ff <= out_shift_ff[7];
        out_shift_ff <= {out_shift_ff[6:0], 1'b0};
      end
    end
  end

  assign serial_out = so_ff;
  assign serial_out_en = so_en_ff;

  // ===========================================================
  // Crossing into the system clock
  logic [2:0] ev_sync_ff;
  logic [2:0] end_sync_ff;
  logic [31:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ev_sync_ff <= 3'h0;
      end_sync_ff <= 3'h0;
      wp_sync_ff <= 2'h3;
    end else begin
      ev_sync_ff <= {ev_sync_ff[1:0], ev_tgl_ff};
      end_sync_ff <= {end_sync_ff[1:0], end_tgl_ff};
      wp_sync_ff <= {wp_sync_ff[0], write_protect_pin_n};
    end
  end

  wire ev_pulse = ev_sync_ff[2] ^ ev_sync_ff[1];
  wire end_pulse = end_sync_ff[2] ^ end_sync_ff[1];
  assign fifo_in_valid = ev_pulse || end_pulse;
  assign fifo_in = end_pulse ? end_word_ff : {ev_word_ff, 8'h00};

  word_fifo #(.WIDTH(32), .DEPTH(4)) cmd_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );

  // ===========================================================
  // Command execution and protection
  wire [7:0] op = fifo_out[31:24];
  wire lock_sel = fifo_out[23:16] == `ID_LOCK_SEL;
  wire [14:0] waddr = fifo_out[22:8];
  wire [7:0] wdata = fifo_out[7:0];
  wire [1:0] blk = nv_bits_ff[1:0];
  wire pin_lock = nv_bits_ff[2] && !wp_sync_ff[1];
  wire in_quarter = waddr >= `PROT_QUARTER_BASE;
  wire in_half = waddr >= `PROT_HALF_BASE;
  wire addr_prot = (blk == 2'b11) || (blk == 2'b10 && in_half) || (blk == 2'b01 && in_quarter);
  wire exec = fifo_out_valid && !busy_ff;
  wire is_wtype = op == `OP_ARRAY_WRITE || op == `OP_ID_WRITE || op == `OP_STATUS_WRITE;
  wire allowed = write_latch_ff;
  wire do_array = exec && allowed && op == `OP_ARRAY_WRITE && !addr_prot;
  wire do_id = exec && allowed && op == `OP_ID_WRITE && !lock_sel && blk != 2'b11;
  wire do_lock = exec && allowed && op == `OP_ID_WRITE && lock_sel;
  wire do_status = exec && allowed && op == `OP_STATUS_WRITE && !pin_lock;
  wire start_busy = do_array || do_id || do_lock || do_status;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      nv_bits_ff <= `SR_NV_RESET;
    end else if (do_status) begin
      nv_bits_ff <= {wdata[`SR_PIN_PROTECT_BIT], wdata[`SR_BLOCK_HI_BIT], wdata[`SR_BLOCK_LO_BIT]};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_latch_ff <= 1'b0;
    end else if (exec && op == `OP_WRITE_ENABLE) begin
      write_latch_ff <= 1'b1;
    end else if (exec && (op == `OP_WRITE_DISABLE || is_wtype)) begin
      write_latch_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= 32'h0;
    end else if (start_busy) begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= 32'(WRITE_CYCLES - 1);
    end else if (busy_ff) begin
      if (busy_cnt_ff == 32'h0) begin
        busy_ff <= 1'b0;
      end else begin
        busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_ff <= 8'h00;
      array_write_valid_ff <= 1'b0;
      array_write_addr_ff <= 15'h0000;
      array_write_data_ff <= 8'h00;
      id_write_valid_ff <= 1'b0;
      id_lock_valid_ff <= 1'b0;
    end else begin
      status_ff <= {nv_bits_ff[2], 3'h0, nv_bits_ff[1:0], write_latch_ff, busy_ff};
      array_write_valid_ff <= do_array;
      array_write_addr_ff <= waddr;
      array_write_data_ff <= wdata;
      id_write_valid_ff <= do_id;
      id_lock_valid_ff <= do_lock;
    end
  end

  assign array_write_valid = array_write_valid_ff;
  assign array_write_addr = array_write_addr_ff;
  assign array_write_data = array_write_data_ff;
  assign id_write_valid = id_write_valid_ff;
  assign id_lock_valid = id_lock_valid_ff;
  assign status_word = status_ff;
endmodule

//--- rtl/eeprom_prot_cfg.svh
`ifndef EEPROM_PROT_CFG_SVH
`define EEPROM_PROT_CFG_SVH

// Status word bit positions
`define SR_PIN_PROTECT_BIT 7
`define SR_BLOCK_HI_BIT 3
`define SR_BLOCK_LO_BIT 2
`define SR_WRITE_LATCH_BIT 1
`define SR_BUSY_BIT 0

// Reset values
`define SR_NV_RESET 3'h0

// Instruction codes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_WRITE 8'h02
`define OP_ID_WRITE 8'h82

// Second byte that selects page lock in the ID write opcode
`define ID_LOCK_SEL 8'h04

// Protected address floors
`define PROT_QUARTER_BASE 15'h6000
`define PROT_HALF_BASE 15'h4000

// Internal write time
`define WRITE_TIME_US 3500
`define CLOCK_MHZ 25
`define WRITE_CYCLES (`WRITE_TIME_US * `CLOCK_MHZ)

`endif

//--- rtl/eeprom_prot_pkg.sv
package eeprom_prot_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_DONE = 5'h10
  } frame_state_t;

  typedef enum logic [2:0] {
    JOB_ARRAY = 3'h1,
    JOB_STATUS = 3'h2,
    JOB_ID = 3'h4
  } job_kind_t;
endpackage

//--- rtl/word_fifo.sv
module word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

//--- verification/eeprom_checker_properties.sv
module eeprom_checker #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic write_protect_pin_n,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic array_write_valid,
  input wire logic [14:0] array_write_addr,
  input wire logic [7:0] array_write_data,
  input wire logic id_write_valid,
  input wire logic id_lock_valid,
  input wire logic [7:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Busy span counter and properties
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  wire busy = status_word[0];
  wire [1:0] bp = status_word[3:2];
  wire any_wr = array_write_valid || id_write_valid || id_lock_valid;
  assign nxt_busy_cnt = busy ? busy_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) busy_cnt_ff <= 32'h0;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_zero_bits: assert property (status_word[6:4] == 3'h0)
    else $error("status bits 6 to 4 not zero");
  a_write_latch: assert property (any_wr |-> status_word[1] || $past(status_word[1], 4))
    else $error("write pulse without write latch");
  a_latch_clear: assert property (any_wr |-> ##[0:8] !status_word[1])
    else $error("write latch not cleared after write");
  a_busy_start: assert property ($rose(any_wr) |-> ##[0:8] busy)
    else $error("busy not raised after write");
  a_busy_span: assert property ($fell(busy) |-> busy_cnt_ff >= WRITE_CYCLES - 2 && busy_cnt_ff <= WRITE_CYCLES + 2)
    else $error("busy length wrong");
  a_idle_busy: assert property (any_wr |-> !$past(busy, 3))
    else $error("write accepted while busy");
  a_block_range: assert property (array_write_valid |-> bp == 2'h0 || (bp == 2'h1 && array_write_addr < 15'h6000) || (bp == 2'h2 && array_write_addr < 15'h4000))
    else $error("write into protected block");
  a_id_whole: assert property (id_write_valid |-> bp != 2'h3)
    else $error("id page write under whole protect");
  a_nv_source: assert property ($changed(status_word[7:2]) |-> $past(busy) or ##[0:8] busy)
    else $error("protect bits changed without write cycle");
  a_out_release: assert property (chip_select_n && $past(chip_select_n) |-> !serial_out_en)
    else $error("serial output driven outside a frame");
  c_array: cover property (array_write_valid);
  c_lock: cover property (id_lock_valid);
  c_busy: cover property ($fell(busy));
endmodule
bind eeprom_status_block_protect eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (.clock(clock), .reset(reset),
  .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
  .write_protect_pin_n(write_protect_pin_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
  .array_write_valid(array_write_valid), .array_write_addr(array_write_addr), .array_write_data(array_write_data),
  .id_write_valid(id_write_valid), .id_lock_valid(id_lock_valid), .status_word(status_word));

//--- verification/spi_host_model.sv
module spi_host_model (
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Mode 0 host, clock runs only inside frames
  logic so_last;
  initial begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    so_last = 1'b0;
  end
  task automatic frame(input logic [7:0] b[$], output logic [7:0] rd);
    logic s;
    chip_select_n = 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        serial_in = b[i][k];
        #24;
        serial_clock = 1'b1;
        // A released output reads as the inverse of the last bit
        s = serial_out_en ? serial_out : ~so_last;
        so_last = s;
        rd = {rd[6:0], s};
        #24;
        serial_clock = 1'b0;
      end
    end
    #24;
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #100;
  endtask
endmodule

//--- verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 20;
  logic clock, reset, wp_n;
  wire sck, cs_n, si, so, so_en, awv, idv, ilv;
  wire [14:0] aw_a;
  wire [7:0] aw_d, sw;
  int err_count, n_tests, pp, bh, bl, latch, busy, id_exp, id_got, lk_exp, lk_got;
  logic [22:0] exp_q[$], got_q[$];
  logic [14:0] addrs [6] = '{15'h0000, 15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
  logic [14:0] a;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  eeprom_status_block_protect #(.WRITE_CYCLES(WC)) u_dut (.clock(clock), .reset(reset), .serial_clock(sck),
    .chip_select_n(cs_n), .serial_in(si), .write_protect_pin_n(wp_n), .serial_out(so), .serial_out_en(so_en),
    .array_write_valid(awv), .array_write_addr(aw_a), .array_write_data(aw_d), .id_write_valid(idv),
    .id_lock_valid(ilv), .status_word(sw));
  spi_host_model u_host (.serial_clock(sck), .chip_select_n(cs_n), .serial_in(si), .serial_out(so),
    .serial_out_en(so_en));
  always @(posedge clock) begin
    if (awv === 1'b1) got_q.push_back({aw_a, aw_d});
    if (idv === 1'b1) id_got++;
    if (ilv === 1'b1) lk_got++;
  end
  // ==========================================
  // Checking, model and commands
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_sw();
    return {pp[0], 3'h0, bh[0], bl[0], latch[0], busy[0]};
  endfunction
  task automatic status_chk();
    logic [7:0] rd;
    repeat (10) @(posedge clock);
    check("status_word", sw, exp_sw());
    if (busy != 0) begin
      repeat (WC) @(posedge clock);
      busy = 0;
      check("status_word", sw, exp_sw());
    end
    u_host.frame({8'h05, 8'($urandom)}, rd);
    check("serial status", rd, exp_sw());
    check("write count", got_q.size(), exp_q.size());
    foreach (exp_q[i]) check("write", got_q[i], exp_q[i]);
    check("id writes", id_got, id_exp);
    check("id locks", lk_got, lk_exp);
    exp_q.delete();
    got_q.delete();
  endtask
  task automatic cmd(input logic [7:0] q[$], input bit settle = 1'b1);
    logic [7:0] rd;
    logic [14:0] ad;
    logic ok;
    u_host.frame(q, rd);
    ad = (q.size() > 2) ? {q[1][6:0], q[2]} : 15'h0;
    case ((busy != 0) ? 8'h00 : q[0])
      8'h06: latch = 1;
      8'h04: latch = 0;
      8'h01: begin
        if (latch != 0 && !(pp != 0 && wp_n === 1'b0)) begin
          pp = q[1][7];
          bh = q[1][3];
          bl = q[1][2];
          busy = 1;
        end
        latch = 0;
      end
      8'h02: begin
        ok = latch != 0 && !(bh != 0 && bl != 0) && !(bh != 0 && ad >= 15'h4000) && !(bl != 0 && ad >= 15'h6000);
        if (ok) exp_q.push_back({ad, q[3]});
        if (ok) busy = 1;
        latch = 0;
      end
      8'h82: begin
        ok = latch != 0 && !(bh != 0 && bl != 0);
        if (ok && q[1] == 8'h04) lk_exp++;
        if (ok && q[1] != 8'h04) id_exp++;
        if (ok) busy = 1;
        latch = 0;
      end
      default: ;
    endcase
    if (settle) status_chk();
  endtask
  task automatic set_wp(input logic v);
    @(posedge clock);
    wp_n <= v;
    repeat (5) @(posedge clock);
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hFED43B34));
    reset <= 1'b1;
    wp_n = 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    status_chk();
    cmd({8'h06});
    cmd({8'h04});
    cmd({8'h02, 8'h00, 8'h10, 8'h5A});
    for (int bp = 0; bp < 4; bp++) begin
      cmd({8'h06});
      cmd({8'h01, 8'(8'h73 | (bp << 2))});
      for (int k = 0; k < 6; k++) begin
        a = (k == 0) ? 15'($urandom) : addrs[k];
        cmd({8'h06});
        cmd({8'h02, 8'(a >> 8), 8'(a), 8'($urandom)});
      end
      cmd({8'h06});
      cmd({8'h82, 8'h00, 8'($urandom % 64), 8'($urandom)});
    end
    cmd({8'h06});
    cmd({8'h01, 8'h00});
    cmd({8'h06});
    cmd({8'h82, 8'h04, 8'h00, 8'($urandom)});
    cmd({8'h06});
    cmd({8'h01, 8'h80});
    set_wp(1'b0);
    cmd({8'h06});
    cmd({8'h01, 8'h0C});
    cmd({8'h06});
    cmd({8'h02, 8'h12, 8'h34, 8'($urandom)});
    set_wp(1'b1);
    cmd({8'h06});
    cmd({8'h01, 8'h00});
    set_wp(1'b0);
    cmd({8'h06});
    cmd({8'h01, 8'h04});
    cmd({8'h06});
    cmd({8'h02, 8'h01, 8'h00, 8'($urandom)}, 1'b0);
    cmd({8'h06}, 1'b0);
    busy = 0;
    cmd({8'h02, 8'h01, 8'h01, 8'h3C});
    summarize();
  end
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule
